// ---- logic/rcs_pkg.sv ----
package rcs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int SYM_US = 16;
  localparam int SYM_CYC = SYM_US * CLK_MHZ;
  localparam int TURN_SHORT_US = 128;
  localparam int TURN_LONG_US = 192;
  localparam int TURN_SHORT_CYC = TURN_SHORT_US * CLK_MHZ;
  localparam int TURN_LONG_CYC = TURN_LONG_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_SIG_THR = 6'h13;
  localparam logic [5:0] ADDR_SYNC = 6'h14;
  localparam logic [5:0] ADDR_TRANSMIT_CONTROL = 6'h15;
  localparam logic [5:0] ADDR_RECEIVE_CONTROL_FIRST = 6'h16;

  // ----------------------------------------------------------------
  // Reset values and field constants
  // ----------------------------------------------------------------
  localparam logic [7:0] THR_RESET = 8'hE0;
  localparam logic [7:0] EST_RESET = 8'h80;
  localparam logic [15:0] SYNC_RESET = 16'hA70F;
  localparam logic [15:0] TRANSMIT_CONTROL_RESET = 16'hA0FF;
  localparam logic [15:0] RECEIVE_CONTROL_FIRST_RESET = 16'h12E5;
  localparam int THR_LSB = 8;
  localparam int AVG_N = 8;
  localparam logic [3:0] FILL_VALID = 4'h9;
  localparam logic [3:0] NIB_SKIP = 4'hF;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [2:0] SYNC_NIBS = 3'h4;
  localparam logic [2:0] HIST_NIBS = 3'h5;

  typedef enum logic [1:0] {
    CCA_RSVD, CCA_LEVEL, CCA_PACKET, CCA_BOTH
  } rcs_clear_channel_rule_select_t;

  // ----------------------------------------------------------------
  // Register layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] tx_buffer_bias_select;
    logic transmit_start_delay_select;
    logic [1:0] tx_varactor_select;
    logic [1:0] tx_mixer_current_select;
    logic [2:0] amplifier_current_adjust;
    logic reserved_one;
    logic [4:0] output_power_level;
  } rcs_transmit_control_t;

  typedef struct packed {
    logic [1:0] reserved_zero;
    logic [1:0] rx_buffer_bias_select;
    logic [1:0] high_gain_compensation_current;
    logic [1:0] medium_gain_compensation_current;
    logic [1:0] low_gain_compensation_current;
    logic [1:0] high_gain_amplifier_current;
    logic [1:0] medium_gain_amplifier_current;
    logic [1:0] low_gain_amplifier_current;
  } rcs_receive_control_first_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } rcs_reg_req_t;

  typedef struct packed {
    logic [7:0] thr_reg;
    logic [15:0] sync_reg;
    rcs_transmit_control_t tx_reg;
    rcs_receive_control_first_t rx_reg;
    logic [15:0] rdata_reg;
    logic [8:0] sym_reg;
    logic [7:0][7:0] samp_reg;
    logic [3:0] fill_reg;
    logic [7:0] est_reg;
    logic valid_reg;
    logic cca_reg;
    logic [12:0] turn_reg;
    logic turn_busy_reg;
    logic tx_start_reg;
    logic [15:0] txw_reg;
    logic [2:0] txleft_reg;
    logic [3:0] txsym_reg;
    logic txsym_vld_reg;
    logic [19:0] hist_reg;
    logic [2:0] hfill_reg;
    logic sync_found_reg;
  } rcs_state_t;

endpackage

// ---- logic/rcs_reg_bank.sv ----
`timescale 1ns/1ps
// Function
// - Signed 8-bit clear-channel threshold in bits 15:8, resets to -32.
// - Clear-channel output pin high while signal strength is below threshold; code sets it below threshold minus hysteresis and clears it at threshold.
// - Read-only signed strength estimate in bits 7:0, mean of 8 symbols.
// - Valid flag set only after receiver on for at least 8 symbols.
// - Estimate resets to -128, meaning no valid estimate.
// - 16-bit sync word, resets 0xA70F, used nibble by nibble from LSB.
// - Transmitter sends zero symbol for every F nibble of sync word.
// - Receiver skips F nibbles and matches only the others.
// - Receiver needs one zero symbol before first required sync symbol.
// - Transmit starts 8 or 12 symbols after strobe, per bit 13.
// - 5-bit output power level in bits 4:0, resets to 31.
// - 3-bit amplifier current adjust in bits 8:6, resets to 3.
// - Tx buffer bias bits 15:14 reset 2; mixer current 10:9 reset 0.
// - Tx varactor select in bits 12:11, resets to 0.
// - Rx buffer bias select in bits 13:12, resets to 1.
// - Three gain compensation currents in 11:10, 9:8, 7:6; reset 0,2,3.
// - Three amplifier main currents in 5:4, 3:2, 1:0; reset 2,1,1.
// - Two-bit rule select; rule 1 uses threshold minus hysteresis.
module rcs_reg_bank #(
  parameter int TX_LONG_CYCLES = rcs_pkg::TURN_LONG_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register access from the serial decoder
  input wire rcs_pkg::rcs_reg_req_t reg_req,
  output logic [15:0] reg_rdata,
  // Receiver side
  input wire logic rx_on,
  input wire logic [7:0] signal_strength_and_channel_threshold_raw,
  input wire logic rx_packet_active,
  input wire logic [3:0] rx_sym,
  input wire logic rx_sym_valid,
  output logic frame_sync_found,
  // Clear-channel control and status
  input wire rcs_pkg::rcs_clear_channel_rule_select_t clear_channel_rule_select,
  input wire logic [2:0] clear_channel_hysteresis,
  output logic cca_pin,
  output logic signal_strength_valid_flag,
  // Transmitter side
  input wire logic transmit_on_strobe,
  output logic tx_start,
  output logic [3:0] tx_sym,
  output logic tx_sym_valid,
  // Analog tuning
  output rcs_pkg::rcs_transmit_control_t tx_tune,
  output rcs_pkg::rcs_receive_control_first_t rx_tune
);
  import rcs_pkg::*;

  // ----------------------------------------------------------------
  // Derived constants
  // ----------------------------------------------------------------
  localparam logic [8:0] SYM_LAST = 9'(SYM_CYC - 1);
  localparam logic [12:0] TURN_SHORT_LAST = 13'(TURN_SHORT_CYC - 1);
  localparam logic [12:0] TURN_LONG_LAST = 13'(TX_LONG_CYCLES - 1);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  rcs_state_t s;
  rcs_state_t n;

  logic sym_tick;
  logic est_upd;
  logic [7:0][7:0] samp_new;
  logic signed [10:0] sum;
  logic signed [9:0] low_lim;
  logic signed [9:0] thr_ext;
  logic signed [9:0] est_ext;
  logic below_low;
  logic at_or_above;
  logic [19:0] hist_new;
  logic [2:0] hfill_new;
  logic [19:0] exp_pat;
  logic [19:0] exp_mask;
  logic [2:0] req_cnt;
  logic sync_match;
  logic [15:0] rd_mux;

  always_comb begin
    n = s;
    sym_tick = 1'b0;
    est_upd = 1'b0;
    samp_new = s.samp_reg;
    sum = 11'sh000;
    low_lim = 10'sh000;
    thr_ext = 10'sh000;
    est_ext = 10'sh000;
    below_low = 1'b0;
    at_or_above = 1'b0;
    hist_new = s.hist_reg;
    hfill_new = s.hfill_reg;
    exp_pat = 20'h00000;
    exp_mask = 20'h00000;
    req_cnt = 3'h0;
    sync_match = 1'b0;
    rd_mux = 16'h0000;

    n.tx_start_reg = 1'b0;
    n.txsym_vld_reg = 1'b0;
    n.sync_found_reg = 1'b0;

    // Free-running symbol timer shared by averaging and transmit
    sym_tick = (s.sym_reg == SYM_LAST);
    n.sym_reg = sym_tick ? 9'h000 : s.sym_reg + 9'h001;

    // --------------------------------------------------------------
    // Register writes
    // --------------------------------------------------------------
    if (reg_req.wr) begin
      case (reg_req.addr)
        ADDR_SIG_THR: n.thr_reg = reg_req.wdata[15:THR_LSB];
        ADDR_SYNC: n.sync_reg = reg_req.wdata;
        // Reserved bits are stored as written; software keeps them
        ADDR_TRANSMIT_CONTROL: n.tx_reg = rcs_transmit_control_t'(reg_req.wdata);
        ADDR_RECEIVE_CONTROL_FIRST: n.rx_reg = rcs_receive_control_first_t'(reg_req.wdata);
        default: n.thr_reg = s.thr_reg;
      endcase
    end

    // --------------------------------------------------------------
    // Register reads, answered one cycle later
    // --------------------------------------------------------------
    case (reg_req.addr)
      ADDR_SIG_THR: rd_mux = {s.thr_reg, s.est_reg};
      ADDR_SYNC: rd_mux = s.sync_reg;
      ADDR_TRANSMIT_CONTROL: rd_mux = s.tx_reg;
      ADDR_RECEIVE_CONTROL_FIRST: rd_mux = s.rx_reg;
      default: rd_mux = 16'h0000;
    endcase
    if (reg_req.rd) begin
      n.rdata_reg = rd_mux;
    end

    // --------------------------------------------------------------
    // Signal-strength averaging
    // --------------------------------------------------------------
    samp_new = {s.samp_reg[6:0], signal_strength_and_channel_threshold_raw};
    for (int i = 0; i < AVG_N; i++) begin
      sum = sum + 11'(signed'(samp_new[i]));
    end
    if (!rx_on) begin
      n.fill_reg = 4'h0;
      n.est_reg = EST_RESET;
      n.valid_reg = 1'b0;
    end else if (sym_tick) begin
      n.samp_reg = samp_new;
      // The first sample may cover a partial symbol, hence one extra
      if (s.fill_reg != FILL_VALID) begin
        n.fill_reg = s.fill_reg + 4'h1;
      end
      if (n.fill_reg == FILL_VALID) begin
        n.est_reg = 8'(sum >>> 3);
        n.valid_reg = 1'b1;
        est_upd = 1'b1;
      end
    end

    // --------------------------------------------------------------
    // Clear-channel assessment
    // --------------------------------------------------------------
    thr_ext = 10'(signed'(s.thr_reg));
    est_ext = 10'(signed'(n.est_reg));
    low_lim = thr_ext - 10'(clear_channel_hysteresis);
    below_low = (est_ext < low_lim);
    at_or_above = (est_ext >= thr_ext);
    case (clear_channel_rule_select)
      CCA_LEVEL: begin
        if (est_upd && below_low) begin
          n.cca_reg = 1'b1;
        end else if (est_upd && at_or_above) begin
          n.cca_reg = 1'b0;
        end
      end
      CCA_PACKET: n.cca_reg = !rx_packet_active;
      CCA_BOTH: begin
        if (rx_packet_active || (est_upd && at_or_above)) begin
          n.cca_reg = 1'b0;
        end else if (est_upd && below_low) begin
          n.cca_reg = 1'b1;
        end
      end
      default: n.cca_reg = s.cca_reg;
    endcase

    // --------------------------------------------------------------
    // Transmit turnaround
    // --------------------------------------------------------------
    if (s.turn_busy_reg) begin
      if (s.turn_reg == 13'h0000) begin
        n.turn_busy_reg = 1'b0;
        n.tx_start_reg = 1'b1;
        n.txw_reg = s.sync_reg;
        n.txleft_reg = SYNC_NIBS;
      end else begin
        n.turn_reg = s.turn_reg - 13'h0001;
      end
    end else if (transmit_on_strobe && s.txleft_reg == 3'h0) begin
      n.turn_busy_reg = 1'b1;
      n.turn_reg = s.tx_reg.transmit_start_delay_select ?
                   TURN_LONG_LAST : TURN_SHORT_LAST;
    end

    // Sync word goes out low nibble first, one per symbol
    if (s.txleft_reg != 3'h0 && sym_tick) begin
      n.txsym_reg = (s.txw_reg[3:0] == NIB_SKIP) ?
                    NIB_ZERO : s.txw_reg[3:0];
      n.txsym_vld_reg = 1'b1;
      n.txw_reg = {4'h0, s.txw_reg[15:4]};
      n.txleft_reg = s.txleft_reg - 3'h1;
    end

    // --------------------------------------------------------------
    // Receive sync search
    // --------------------------------------------------------------
    // Skipped nibbles drop out; zeros shifted in form the leading zero
    for (int i = 0; i < 4; i++) begin
      if (s.sync_reg[4*i +: 4] != NIB_SKIP) begin
        exp_pat = {exp_pat[15:0], s.sync_reg[4*i +: 4]};
        req_cnt = req_cnt + 3'h1;
      end
    end
    for (int j = 0; j < 5; j++) begin
      if (3'(j) <= req_cnt) begin
        exp_mask[4*j +: 4] = 4'hF;
      end
    end
    hist_new = {s.hist_reg[15:0], rx_sym};
    hfill_new = (s.hfill_reg == HIST_NIBS) ?
                HIST_NIBS : s.hfill_reg + 3'h1;
    sync_match = ((hist_new & exp_mask) == (exp_pat & exp_mask))
                 && (hfill_new > req_cnt);
    if (!rx_on) begin
      n.hfill_reg = 3'h0;
    end else if (rx_sym_valid) begin
      n.hist_reg = hist_new;
      n.hfill_reg = sync_match ? 3'h0 : hfill_new;
      n.sync_found_reg = sync_match;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.thr_reg <= THR_RESET;
      s.sync_reg <= SYNC_RESET;
      s.tx_reg <= rcs_transmit_control_t'(TRANSMIT_CONTROL_RESET);
      s.rx_reg <= rcs_receive_control_first_t'(RECEIVE_CONTROL_FIRST_RESET);
      s.est_reg <= EST_RESET;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from state flops
  // ----------------------------------------------------------------
  assign reg_rdata = s.rdata_reg;
  assign frame_sync_found = s.sync_found_reg;
  assign cca_pin = s.cca_reg;
  assign signal_strength_valid_flag = s.valid_reg;
  assign tx_start = s.tx_start_reg;
  assign tx_sym = s.txsym_reg;
  assign tx_sym_valid = s.txsym_vld_reg;
  // Tuning only changes on a write or reset
  assign tx_tune = s.tx_reg;
  assign rx_tune = s.rx_reg;

endmodule

// ---- verification/rcs_host_model.sv ----
`timescale 1ns/1ps
module rcs_host_model (
  // Clock
  input wire logic clk_sys,
  // Register request toward the device
  output rcs_pkg::rcs_reg_req_t reg_req
);
  import rcs_pkg::*;
  initial reg_req = '0;
  task automatic access(input logic [5:0] a, input logic [15:0] d,
                        input logic w);
    logic [15:0] v;
    v = d;
    if (w && a == ADDR_TRANSMIT_CONTROL) v[5] = 1'b1;
    if (w && a == ADDR_RECEIVE_CONTROL_FIRST) v[15:14] = 2'h0;
    @(negedge clk_sys);
    reg_req <= '{addr: a, wdata: v, wr: w, rd: !w};
    @(negedge clk_sys);
    // Idle lines carry a changing pattern, never the last value
    reg_req <= '{addr: ~a, wdata: ~v, wr: 1'b0, rd: 1'b0};
  endtask
endmodule

// ---- verification/rcs_reg_bank_asserts.sv ----
`timescale 1ns/1ps
module rcs_reg_bank_asserts #(
  parameter int TX_LONG_CYCLES = 4800
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register access
  input wire rcs_pkg::rcs_reg_req_t reg_req,
  input wire logic [15:0] reg_rdata,
  // Receiver and clear channel
  input wire logic rx_on,
  input wire logic [7:0] signal_strength_and_channel_threshold_raw,
  input wire logic rx_packet_active,
  input wire logic [3:0] rx_sym,
  input wire logic rx_sym_valid,
  input wire logic frame_sync_found,
  input wire rcs_pkg::rcs_clear_channel_rule_select_t clear_channel_rule_select,
  input wire logic [2:0] clear_channel_hysteresis,
  input wire logic cca_pin,
  input wire logic signal_strength_valid_flag,
  // Transmitter and tuning
  input wire logic transmit_on_strobe,
  input wire logic tx_start,
  input wire logic [3:0] tx_sym,
  input wire logic tx_sym_valid,
  input wire rcs_pkg::rcs_transmit_control_t tx_tune,
  input wire rcs_pkg::rcs_receive_control_first_t rx_tune
);
  import rcs_pkg::*;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Design sees reset two flops late, so checks wait for that too
  logic [2:0] live_reg;
  logic [12:0] on_reg;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      live_reg <= 3'h0;
      on_reg <= 13'h0000;
    end else begin
      live_reg <= {live_reg[1:0], 1'b1};
      if (!rx_on) on_reg <= 13'h0000;
      else if (on_reg != 13'h1FFF) on_reg <= on_reg + 13'h0001;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!live_reg[2]);
  sequence s_found;
    frame_sync_found;
  endsequence
  sequence s_long_start;
    tx_start && tx_tune.transmit_start_delay_select;
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_valid_min_on: assert property (
    signal_strength_valid_flag |-> on_reg >= 13'h0C80)
    else $error("valid flag before eight symbols");
  a_valid_drop: assert property (!rx_on |=> !signal_strength_valid_flag)
    else $error("valid flag kept with receiver off");
  a_zero_replace: assert property (tx_sym_valid |-> tx_sym != NIB_SKIP)
    else $error("skip nibble sent on air");
  a_sym_spacing: assert property (tx_sym_valid |=> !tx_sym_valid [*8])
    else $error("symbols too close");
  a_long_turn: assert property (
    s_long_start |-> $past(transmit_on_strobe, TX_LONG_CYCLES + 1))
    else $error("long turnaround length wrong");
  a_start_pulse: assert property (tx_start |=> !tx_start)
    else $error("start pulse too long");
  a_sync_pulse: assert property (s_found |=> !frame_sync_found)
    else $error("sync pulse too long");
  a_sync_cause: assert property (s_found |-> $past(rx_sym_valid))
    else $error("sync found without symbol");
  a_tune_static: assert property (
    !reg_req.wr |=> $stable(tx_tune) && $stable(rx_tune))
    else $error("tuning changed without write");
  a_packet_rule: assert property (
    clear_channel_rule_select == CCA_PACKET
    |=> cca_pin == !$past(rx_packet_active))
    else $error("packet rule wrong");
  a_both_clear: assert property (
    clear_channel_rule_select == CCA_BOTH && rx_packet_active |=> !cca_pin)
    else $error("combined rule not cleared");
endmodule

// ---- verification/tb_rcs_reg_bank.sv ----
`timescale 1ns/1ps
module tb_rcs_reg_bank;
  import rcs_pkg::*;
  localparam int LONG = 40;
  logic clk_sys, reset_n, rx_on, rx_packet_active, rx_sym_valid, strobe;
  logic found, cca, valid, tx_start, tx_sym_valid, pend, p;
  logic [7:0] signal_strength_and_channel_threshold_raw;
  logic [3:0] rx_sym, tx_sym;
  logic [2:0] hyst;
  logic [15:0] reg_rdata;
  logic [15:0] e16;
  logic [3:0] e4;
  rcs_clear_channel_rule_select_t rule;
  rcs_reg_req_t reg_req;
  rcs_transmit_control_t tx_tune;
  rcs_receive_control_first_t rx_tune;
  logic [15:0] rd_q[$];
  logic [3:0] sym_q[$];
  int failures, check_count, cycles, n;
  rcs_host_model rcs_host_model_i (.clk_sys(clk_sys), .reg_req(reg_req));
  rcs_reg_bank #(.TX_LONG_CYCLES(LONG)) rcs_reg_bank_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .rx_on(rx_on), .signal_strength_and_channel_threshold_raw(signal_strength_and_channel_threshold_raw),
    .rx_packet_active(rx_packet_active), .rx_sym(rx_sym),
    .rx_sym_valid(rx_sym_valid), .frame_sync_found(found),
    .clear_channel_rule_select(rule), .clear_channel_hysteresis(hyst),
    .cca_pin(cca), .signal_strength_valid_flag(valid),
    .transmit_on_strobe(strobe), .tx_start(tx_start), .tx_sym(tx_sym),
    .tx_sym_valid(tx_sym_valid), .tx_tune(tx_tune), .rx_tune(rx_tune));
  // ----------------------------------------------------------------
  // Compare, report and bus tasks
  // ----------------------------------------------------------------
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic results();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    rcs_host_model_i.access(a, d, 1'b1);
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    rd_q.push_back(e);
    rcs_host_model_i.access(a, 16'h0000, 1'b0);
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and result monitor
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    pend <= reg_req.rd;
    cycles++;
    if (cycles == 30000) begin
      failures++;
      $display("watchdog expired");
      results();
    end
  end
  always @(negedge clk_sys) begin
    if (pend === 1'b1) begin
      e16 = rd_q.size() ? rd_q.pop_front() : 16'hXXXX;
      chk_word(reg_rdata, e16);
    end
    if (tx_sym_valid === 1'b1) begin
      e4 = sym_q.size() ? sym_q.pop_front() : 4'hX;
      chk_word({12'h000, tx_sym}, {12'h000, e4});
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] w;
    logic [7:0] v;
    failures = 0;
    check_count = 0;
    cycles = 0;
    reset_n = 1'b0;
    {rx_on, rx_packet_active, rx_sym_valid, strobe, rx_sym} = '0;
    signal_strength_and_channel_threshold_raw = 8'h00;
    hyst = 3'h7;
    rule = CCA_LEVEL;
    w = 16'($urandom(32'h01C35843));
    repeat (20) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    rd(ADDR_SIG_THR, 16'hE080);
    rd(ADDR_SYNC, 16'hA70F);
    rd(ADDR_TRANSMIT_CONTROL, 16'hA0FF);
    rd(ADDR_RECEIVE_CONTROL_FIRST, 16'h12E5);
    rd(6'h17, 16'h0000);
    chk_word(tx_tune, 16'hA0FF);
    done("reset values");
    v = 8'($urandom());
    wr(ADDR_SIG_THR, {v, 8'($urandom())});
    rd(ADDR_SIG_THR, {v, 8'h80});
    wr(ADDR_SIG_THR, 16'hE000);
    rd(ADDR_SIG_THR, 16'hE080);
    w = 16'($urandom()) | 16'h0020;
    wr(ADDR_TRANSMIT_CONTROL, w);
    rd(ADDR_TRANSMIT_CONTROL, w);
    chk_word(tx_tune, w);
    w = 16'($urandom()) & 16'h3FFF;
    wr(ADDR_RECEIVE_CONTROL_FIRST, w);
    rd(ADDR_RECEIVE_CONTROL_FIRST, w);
    chk_word(rx_tune, w);
    done("write and read back");
    for (int k = 0; k < 2; k++) begin
      w = 16'($urandom());
      w[7:0] = 8'hF5;
      wr(ADDR_SYNC, w);
      rd(ADDR_SYNC, w);
      for (int i = 0; i < 4; i++) begin
        sym_q.push_back(w[4*i+:4] == 4'hF ? 4'h0 : w[4*i+:4]);
      end
      wr(ADDR_TRANSMIT_CONTROL, k ? 16'hA0FF : 16'h80FF);
      @(negedge clk_sys);
      strobe = 1'b1;
      @(negedge clk_sys);
      strobe = 1'b0;
      n = 0;
      while (tx_start !== 1'b1 && n < 5000) begin
        @(negedge clk_sys);
        n++;
      end
      chk_word(16'(n), k ? 16'(LONG) : 16'h0C80);
      while (sym_q.size() > 0 && n < 9000) begin
        @(negedge clk_sys);
        n++;
      end
      chk_word(16'(sym_q.size()), 16'h0000);
    end
    done("transmit");
    v = 8'hCE - 8'($urandom_range(50));
    signal_strength_and_channel_threshold_raw = v;
    hyst = 3'($urandom());
    rx_on = 1'b1;
    @(negedge clk_sys);
    rx_sym_valid = 1'b1;
    for (int i = 0; i < 4; i++) if (w[4*i+:4] != 4'hF) begin
      @(negedge clk_sys);
      rx_sym = w[4*i+:4];
    end
    @(negedge clk_sys);
    rx_sym_valid = 1'b0;
    chk_bit(found, 1'b1);
    n = 0;
    while (valid !== 1'b1 && n < 5000) begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    chk_bit(valid, 1'b1);
    chk_bit(cca, 1'b1);
    rd(ADDR_SIG_THR, {8'hE0, v});
    rx_on = 1'b0;
    rd(ADDR_SIG_THR, 16'hE080);
    done("receive");
    rule = CCA_PACKET;
    for (int i = 0; i < 20; i++) begin
      p = rx_packet_active;
      @(negedge clk_sys);
      chk_bit(cca, !p);
      rx_packet_active = 1'($urandom());
    end
    rule = CCA_BOTH;
    repeat (20) begin
      @(negedge clk_sys);
      rx_packet_active = 1'($urandom());
    end
    // Reserved rule must hold the pin whatever the packet state
    rule = CCA_RSVD;
    @(negedge clk_sys);
    p = cca;
    repeat (4) begin
      rx_packet_active = 1'($urandom());
      @(negedge clk_sys);
      chk_bit(cca, p);
    end
    done("clear channel rules");
    results();
  end
endmodule
bind rcs_reg_bank rcs_reg_bank_asserts #(
  .TX_LONG_CYCLES(TX_LONG_CYCLES)
) rcs_reg_bank_asserts_i (
  .clk_sys(clk_sys), .reset_n(reset_n), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .rx_on(rx_on), .signal_strength_and_channel_threshold_raw(signal_strength_and_channel_threshold_raw),
  .rx_packet_active(rx_packet_active), .rx_sym(rx_sym),
  .rx_sym_valid(rx_sym_valid), .frame_sync_found(frame_sync_found),
  .clear_channel_rule_select(clear_channel_rule_select),
  .clear_channel_hysteresis(clear_channel_hysteresis), .cca_pin(cca_pin),
  .signal_strength_valid_flag(signal_strength_valid_flag),
  .transmit_on_strobe(transmit_on_strobe), .tx_start(tx_start),
  .tx_sym(tx_sym), .tx_sym_valid(tx_sym_valid), .tx_tune(tx_tune),
  .rx_tune(rx_tune));
